/* include/tmc_defines.svh */
// Constants of the 16-bit timer/counter: offsets, fields, resets, timing.
// Assumes an AHB-Lite slave with one 32-bit word per register.
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH
`define TMC_OFF_CTRL 8'h00
`define TMC_OFF_LOW 8'h04
`define TMC_OFF_HIGH 8'h08
`define TMC_OFF_STAT 8'h0C
`define TMC_OFF_MASK 8'h10
`define TMC_BIT_RUN 0
`define TMC_BIT_SRC 1
`define TMC_BIT_BYPASS 2
`define TMC_BIT_OSCEN 3
`define TMC_BIT_PS_LO 4
`define TMC_BIT_PS_HI 5
`define TMC_BIT_SYSCLK 6
`define TMC_BIT_WIDE 7
`define TMC_BIT_OVF 0
`define TMC_CTRL_RESET 8'h00
`define TMC_COUNT_RESET 16'h0000
`define TMC_COUNT_MAX 16'hFFFF
`define TMC_STAT_RESET 8'h00
`define TMC_MASK_RESET 8'h00
`define TMC_CTRL_WMASK 8'hBF
`define TMC_INSTR_DIV 4
`define TMC_DIV_LAST 2'h3
`endif

/* include/tmc_pkg.sv */
// Types shared by the 16-bit timer/counter design.
// Assumes tmc_defines.svh for all numeric constants.
package tmc_pkg;
  typedef logic [7:0] tmc_byte_t;
  typedef logic [15:0] tmc_count_t;
  typedef logic [2:0] tmc_pre_t;
  typedef enum logic [2:0] {
    TMC_REG_NONE = 3'h0,
    TMC_REG_CTRL = 3'h1,
    TMC_REG_LOW = 3'h3,
    TMC_REG_HIGH = 3'h2,
    TMC_REG_STAT = 3'h6,
    TMC_REG_MASK = 3'h7
  } tmc_reg_e;
endpackage

/* rtl/tmc_timer.sv */
// 16-bit timer/counter with prescaler, buffered wide access and overflow irq.
// Assumes an AHB-Lite master on clk; pins are asynchronous to clk.
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "tmc_defines.svh"

module tmc_timer (
  input wire logic clk, // 200 MHz system clock
  input wire logic srst, // Sync reset, high
  input wire logic clk_en, // Freezes all state when low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write flag
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, OKAY
  input wire logic ext_clock_pin, // External count clock pin
  input wire logic osc_input_pin, // Dedicated oscillator output level
  input wire logic sysclk_from_osc, // Clock control: sysclk from osc
  input wire logic pm_sleep, // Power-managed mode active
  input wire logic special_trigger, // Compare-match trigger pulse
  output logic osc_enable, // Oscillator power enable
  output logic osc_pins_claimed, // Pins forced input, read zero
  output logic irq // Level interrupt
);
  import tmc_pkg::*;

  function automatic tmc_reg_e tmc_decode(input logic [31:0] a);
    tmc_reg_e r;
    r = TMC_REG_NONE;
    if (a[31:8] == 24'h000000) begin
      case (a[7:0])
        `TMC_OFF_CTRL: r = TMC_REG_CTRL;
        `TMC_OFF_LOW: r = TMC_REG_LOW;
        `TMC_OFF_HIGH: r = TMC_REG_HIGH;
        `TMC_OFF_STAT: r = TMC_REG_STAT;
        `TMC_OFF_MASK: r = TMC_REG_MASK;
        default: r = TMC_REG_NONE;
      endcase
    end
    return r;
  endfunction

  function automatic tmc_pre_t tmc_ps_mask(input logic [1:0] ps);
    tmc_pre_t m;
    case (ps)
      2'h0: m = 3'h0;
      2'h1: m = 3'h1;
      2'h2: m = 3'h3;
      default: m = 3'h7;
    endcase
    return m;
  endfunction

  // Input sampling group
  logic ext_s1_reg, ext_s1_next;
  logic ext_s2_reg, ext_s2_next;
  logic osc_s1_reg, osc_s1_next;
  logic osc_s2_reg, osc_s2_next;
  logic lvl_prev_reg, lvl_prev_next;
  logic edge_dly_reg, edge_dly_next;
  logic [1:0] div_reg, div_next;
  logic ext_lvl;
  logic edge_now;
  logic div_tick;
  logic src_tick;

  // Register and counter group
  tmc_byte_t ctrl_reg, ctrl_next;
  tmc_count_t cnt_reg, cnt_next;
  tmc_byte_t hbuf_reg, hbuf_next;
  tmc_pre_t pre_reg, pre_next;
  tmc_byte_t stat_reg, stat_next;
  tmc_byte_t mask_reg, mask_next;
  tmc_reg_e wsel_reg, wsel_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic irq_reg, irq_next;
  logic claim_reg, claim_next;
  logic oscen_reg, oscen_next;
  logic accept;
  tmc_reg_e asel;
  logic rd_lo;
  logic wr_lo;
  logic wr_hi;
  logic inc;
  logic wide;
  tmc_pre_t pmask;

  assign wide = ctrl_reg[`TMC_BIT_WIDE];
  assign accept = hsel && htrans[1] && hready;
  assign asel = tmc_decode(haddr);
  assign rd_lo = accept && !hwrite && asel == TMC_REG_LOW;
  assign wr_lo = wsel_reg == TMC_REG_LOW;
  assign wr_hi = wsel_reg == TMC_REG_HIGH;

  always_comb begin
    ext_s1_next = ext_clock_pin;
    ext_s2_next = ext_s1_reg;
    osc_s1_next = osc_input_pin;
    osc_s2_next = osc_s1_reg;
    // Oscillator edges replace the pin once it is enabled
    ext_lvl = ctrl_reg[`TMC_BIT_OSCEN] ? osc_s2_reg : ext_s2_reg;
    lvl_prev_next = ext_lvl;
    edge_now = ext_lvl && !lvl_prev_reg;
    edge_dly_next = edge_now;
    div_next = pm_sleep ? div_reg : div_reg + 2'h1;
    div_tick = div_reg == `TMC_DIV_LAST && !pm_sleep;
    if (ctrl_reg[`TMC_BIT_SRC]) begin
      // Bypassed edges keep counting in power-managed modes
      if (ctrl_reg[`TMC_BIT_BYPASS]) begin
        src_tick = edge_now;
      end else begin
        // Synchronised path needs the running system clock
        src_tick = edge_dly_reg && !pm_sleep;
      end
    end else begin
      src_tick = div_tick;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      lvl_prev_reg <= 1'b0;
      edge_dly_reg <= 1'b0;
      div_reg <= 2'h0;
    end else if (clk_en) begin
      ext_s1_reg <= ext_s1_next;
      ext_s2_reg <= ext_s2_next;
      osc_s1_reg <= osc_s1_next;
      osc_s2_reg <= osc_s2_next;
      lvl_prev_reg <= lvl_prev_next;
      edge_dly_reg <= edge_dly_next;
      div_reg <= div_next;
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    cnt_next = cnt_reg;
    hbuf_next = hbuf_reg;
    pre_next = pre_reg;
    stat_next = stat_reg;
    mask_next = mask_reg;
    wsel_next = TMC_REG_NONE;
    hrdata_next = hrdata_reg;
    pmask = tmc_ps_mask(ctrl_reg[`TMC_BIT_PS_HI:`TMC_BIT_PS_LO]);
    inc = 1'b0;
    if (accept) begin
      wsel_next = hwrite ? asel : TMC_REG_NONE;
    end
    if (accept && !hwrite) begin
      hrdata_next = 32'h00000000;
      case (asel)
        TMC_REG_CTRL: begin
          hrdata_next[7:0] = ctrl_reg;
          hrdata_next[`TMC_BIT_SYSCLK] = sysclk_from_osc;
        end
        TMC_REG_LOW: hrdata_next[7:0] = cnt_reg[7:0];
        TMC_REG_HIGH: begin
          hrdata_next[7:0] = wide ? hbuf_reg : cnt_reg[15:8];
        end
        TMC_REG_STAT: hrdata_next[7:0] = stat_reg;
        TMC_REG_MASK: hrdata_next[7:0] = mask_reg;
        default: hrdata_next = 32'h00000000;
      endcase
    end
    if (rd_lo && wide) begin
      hbuf_next = cnt_reg[15:8];
    end
    // Counting path
    if (ctrl_reg[`TMC_BIT_RUN] && src_tick) begin
      pre_next = pre_reg + 3'h1;
      inc = (pre_reg & pmask) == pmask;
    end
    if (inc) begin
      cnt_next = cnt_reg + 16'h0001;
      if (cnt_reg == `TMC_COUNT_MAX) begin
        stat_next[`TMC_BIT_OVF] = 1'b1;
      end
    end
    if (special_trigger) begin
      cnt_next = `TMC_COUNT_RESET;
    end
    // Writes land in the data phase; low and narrow high writes override count and trigger
    case (wsel_reg)
      TMC_REG_CTRL: begin
        ctrl_next = hwdata[7:0] & `TMC_CTRL_WMASK;
      end
      TMC_REG_LOW: begin
        cnt_next[7:0] = hwdata[7:0];
        cnt_next[15:8] = wide ? hbuf_reg : cnt_reg[15:8];
        pre_next = 3'h0;
      end
      TMC_REG_HIGH: begin
        if (wide) begin
          hbuf_next = hwdata[7:0];
        end else begin
          cnt_next = {hwdata[7:0], cnt_reg[7:0]};
        end
      end
      TMC_REG_STAT: begin
        // Clear by one, but a fresh overflow still wins
        stat_next = stat_reg & ~hwdata[7:0];
        if (inc && cnt_reg == `TMC_COUNT_MAX) begin
          stat_next[`TMC_BIT_OVF] = 1'b1;
        end
      end
      TMC_REG_MASK: mask_next = hwdata[7:0];
      default: ctrl_next = ctrl_reg;
    endcase
    stat_next[7:1] = 7'h00;
    mask_next[7:1] = 7'h00;
    irq_next = |(stat_next & mask_next);
    claim_next = ctrl_next[`TMC_BIT_RUN];
    oscen_next = ctrl_next[`TMC_BIT_OSCEN];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= `TMC_CTRL_RESET;
      cnt_reg <= `TMC_COUNT_RESET;
      hbuf_reg <= 8'h00;
      pre_reg <= 3'h0;
      stat_reg <= `TMC_STAT_RESET;
      mask_reg <= `TMC_MASK_RESET;
      wsel_reg <= TMC_REG_NONE;
      hrdata_reg <= 32'h00000000;
      irq_reg <= 1'b0;
      claim_reg <= 1'b0;
      oscen_reg <= 1'b0;
    end else if (clk_en) begin
      ctrl_reg <= ctrl_next;
      cnt_reg <= cnt_next;
      hbuf_reg <= hbuf_next;
      pre_reg <= pre_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      wsel_reg <= wsel_next;
      hrdata_reg <= hrdata_next;
      irq_reg <= irq_next;
      claim_reg <= claim_next;
      oscen_reg <= oscen_next;
    end
  end

  // Zero wait states, so ready and response are constant flops
  logic ready_reg;
  logic resp_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      ready_reg <= 1'b1;
      resp_reg <= 1'b0;
    end else if (clk_en) begin
      ready_reg <= 1'b1;
      resp_reg <= 1'b0;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = ready_reg;
  assign hresp = resp_reg;
  assign irq = irq_reg;
  assign osc_pins_claimed = claim_reg;
  assign osc_enable = oscen_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_hold_stopped: assert property (
    clk_en && !ctrl_reg[`TMC_BIT_RUN] && !special_trigger
    && wsel_reg == TMC_REG_NONE |=> $stable(cnt_reg))
    else $error("counter moved while stopped");

  a_wrap_zero: assert property (
    clk_en && inc && cnt_reg == `TMC_COUNT_MAX && !special_trigger
    && wsel_reg == TMC_REG_NONE
    |=> cnt_reg == 16'h0000 && stat_reg[`TMC_BIT_OVF])
    else $error("wrap did not clear counter and set flag");

  a_irq_follows: assert property (
    clk_en && stat_reg[`TMC_BIT_OVF] && mask_reg[`TMC_BIT_OVF]
    && wsel_reg != TMC_REG_STAT && wsel_reg != TMC_REG_MASK
    |-> irq_reg ##1 irq_reg)
    else $error("irq dropped with unmasked flag");

  a_trig_reset: assert property (
    clk_en && special_trigger && wsel_reg == TMC_REG_NONE
    |=> cnt_reg == 16'h0000)
    else $error("trigger did not reset counter");

  a_write_wins: assert property (
    clk_en && special_trigger && wr_lo
    |=> cnt_reg[7:0] == $past(hwdata[7:0]))
    else $error("trigger beat a low byte write");

  a_lo_read_snap: assert property (
    clk_en && rd_lo && wide && wsel_reg != TMC_REG_HIGH
    |=> hbuf_reg == $past(cnt_reg[15:8]))
    else $error("low read did not snapshot high byte");

  a_wide_load: assert property (
    clk_en && wr_lo && wide
    |=> cnt_reg == {$past(hbuf_reg), $past(hwdata[7:0])} && pre_reg == 3'h0)
    else $error("wide low write failed to load both bytes");

  a_hi_buffered: assert property (
    clk_en && wr_hi && wide && !special_trigger && !inc
    |=> $stable(cnt_reg) && hbuf_reg == $past(hwdata[7:0]))
    else $error("wide high write touched the counter");

  a_hi_keeps_pre: assert property (
    clk_en && wr_hi && !src_tick |=> $stable(pre_reg))
    else $error("high write disturbed prescaler");

  a_pins_claim: assert property (
    clk_en |=> osc_pins_claimed == ctrl_reg[`TMC_BIT_RUN])
    else $error("pin claim out of step with run bit");

  a_int_no_sync: assert property (
    clk_en && ctrl_reg[`TMC_BIT_RUN] && !ctrl_reg[`TMC_BIT_SRC]
    && !pm_sleep |-> src_tick == (div_reg == `TMC_DIV_LAST))
    else $error("internal source not on instruction clock");

  a_hi_read_buf: assert property (
    clk_en && accept && !hwrite && asel == TMC_REG_HIGH && wide
    |=> hrdata_reg[7:0] == $past(hbuf_reg))
    else $error("wide high read bypassed the buffer");

  a_sync_sleep_stop: assert property (
    clk_en && ctrl_reg[`TMC_BIT_SRC] && !ctrl_reg[`TMC_BIT_BYPASS]
    && pm_sleep |-> !src_tick)
    else $error("synchronised count ran in sleep");

  a_bypass_counts: assert property (
    clk_en && ctrl_reg[`TMC_BIT_SRC] && ctrl_reg[`TMC_BIT_BYPASS]
    && edge_now |-> src_tick)
    else $error("bypassed edge not counted");

  a_narrow_high: assert property (
    clk_en && wr_hi && !wide
    |=> cnt_reg == {$past(hwdata[7:0]), $past(cnt_reg[7:0])})
    else $error("narrow high write not direct");

  a_flag_sticky: assert property (
    clk_en && stat_reg[`TMC_BIT_OVF] && wsel_reg != TMC_REG_STAT
    |=> stat_reg[`TMC_BIT_OVF])
    else $error("overflow flag dropped without clear");

  c_write_trig: cover property (clk_en && special_trigger && wr_lo);
  c_wrap: cover property (clk_en && inc && cnt_reg == `TMC_COUNT_MAX);
  c_trigger: cover property (clk_en && special_trigger);
  c_wide_read: cover property (clk_en && rd_lo && wide);
  c_ext_tick: cover property (ctrl_reg[`TMC_BIT_SRC] && src_tick);
endmodule

/* tb/tmc_clk_src.sv */
// Behavioural count source: external clock pin and crystal oscillator, both pulsed at a 40 ns period.
// Assumes the bench calls burst; both pins stand low between bursts.
`timescale 1ns/100ps
module tmc_clk_src (
  input wire logic osc_enable, // Oscillator power from the timer
  output logic ext_clock_pin, // External count clock
  output logic osc_input_pin // Crystal oscillator level
);
  initial begin
    ext_clock_pin = 1'b0;
    osc_input_pin = 1'b0;
  end
  // Offset and 40 ns period keep pin changes off both clock edges
  task automatic burst(input int n, input bit use_osc);
    #1.3;
    for (int i = 0; i < n; i++) begin
      if (use_osc)
        osc_input_pin = osc_enable;
      else
        ext_clock_pin = 1'b1;
      #17.5;
      ext_clock_pin = 1'b0;
      osc_input_pin = 1'b0;
      #22.5;
    end
  endtask
endmodule

/* tb/tmc_timer_tb.sv */
// Self-checking bench of the timer/counter over AHB-Lite.
// Assumes the zero-wait slave and the clock source model.
`timescale 1ns/100ps
`include "tmc_defines.svh"
module tmc_timer_tb;
  logic clk, srst, clk_en, hsel, hwrite, sysclk_from_osc, pm_sleep;
  logic special_trigger, hreadyout, hresp, osc_enable;
  logic osc_pins_claimed, irq, ext_clock_pin, osc_input_pin;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0] htrans;
  int fails, n_checks;

  tmc_timer u_dut (
    .clk(clk), .srst(srst), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .ext_clock_pin(ext_clock_pin), .osc_input_pin(osc_input_pin),
    .sysclk_from_osc(sysclk_from_osc), .pm_sleep(pm_sleep),
    .special_trigger(special_trigger), .osc_enable(osc_enable),
    .osc_pins_claimed(osc_pins_claimed), .irq(irq)
  );
  tmc_clk_src u_src (
    .osc_enable(osc_enable), .ext_clock_pin(ext_clock_pin),
    .osc_input_pin(osc_input_pin)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int exp_ticks(input int cycles, input int code);
    return cycles / (4 << code);
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Counts whose phase against the tick divider is free get one of slack
  task automatic check_near(input string what, input int exp,
                            input logic [31:0] got);
    n_checks++;
    if ((^got) === 1'bx || got > exp + 1 || got + 1 < exp) begin
      fails++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    rd = hrdata;
    if (n >= 64) begin
      fails++;
      finish_test();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    logic [7:0] ctl;
    logic [31:0] v;
    int n;
    srst = 1'b1;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    sysclk_from_osc = 1'b0;
    pm_sleep = 1'b0;
    special_trigger = 1'b0;
    seed = 32'h0000548D;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(0, 8'(i * 4), 32'h0);
      check_val("reset value", 32'h0, rd);
      check_val("response", 32'h0, hresp);
    end
    bus(0, 8'h40, 32'h0);
    check_val("unmapped read", 32'h0, rd);
    $display("test reset done");
    for (int b = 0; b < 2; b++) begin
      sysclk_from_osc <= b[0];
      bus(1, `TMC_OFF_CTRL, b[0] ? 32'h0 : 32'h40);
      bus(0, `TMC_OFF_CTRL, 32'h0);
      check_val("sysclk flag", {25'h0, b[0], 6'h0}, rd);
    end
    $display("test flag done");
    for (int c = 0; c < 4; c++) begin
      ctl = 8'h01 | 8'(c << 4) | 8'(rnd() & 32'h00000004);
      bus(1, `TMC_OFF_CTRL, {24'h0, ctl});
      bus(1, `TMC_OFF_LOW, 32'h0);
      repeat (40 << c) @(posedge clk);
      bus(1, `TMC_OFF_CTRL, 32'h0);
      bus(0, `TMC_OFF_LOW, 32'h0);
      check_near("prescale count", exp_ticks(40 << c, c), rd);
      v = rd;
      check_val("pins claimed", 32'h0, osc_pins_claimed);
      repeat (20) @(posedge clk);
      bus(0, `TMC_OFF_LOW, 32'h0);
      check_val("held count", v, rd);
    end
    $display("test prescale done");
    v = rnd();
    bus(1, `TMC_OFF_CTRL, 32'h80);
    bus(1, `TMC_OFF_HIGH, {24'h0, v[15:8]});
    bus(1, `TMC_OFF_LOW, {24'h0, v[7:0]});
    bus(1, `TMC_OFF_HIGH, {24'h0, ~v[15:8]});
    bus(0, `TMC_OFF_HIGH, 32'h0);
    check_val("high buffer", {24'h0, ~v[15:8]}, rd);
    bus(0, `TMC_OFF_LOW, 32'h0);
    check_val("wide low", {24'h0, v[7:0]}, rd);
    bus(0, `TMC_OFF_HIGH, 32'h0);
    check_val("wide high", {24'h0, v[15:8]}, rd);
    $display("test wide done");
    bus(1, `TMC_OFF_HIGH, 32'hFF);
    bus(1, `TMC_OFF_LOW, 32'hFE);
    bus(1, `TMC_OFF_MASK, 32'h1);
    bus(1, `TMC_OFF_CTRL, 32'h81);
    n = 0;
    while (irq !== 1'b1 && n < 64) begin
      @(posedge clk);
      n++;
    end
    check_val("irq on wrap", 32'h1, irq);
    bus(1, `TMC_OFF_CTRL, 32'h80);
    bus(0, `TMC_OFF_LOW, 32'h0);
    bus(0, `TMC_OFF_HIGH, 32'h0);
    check_val("wrapped high", 32'h0, rd);
    bus(1, `TMC_OFF_MASK, 32'h0);
    repeat (2) @(posedge clk);
    check_val("masked irq", 32'h0, irq);
    bus(1, `TMC_OFF_MASK, 32'h1);
    bus(1, `TMC_OFF_STAT, 32'h1);
    repeat (2) @(posedge clk);
    check_val("cleared irq", 32'h0, irq);
    special_trigger <= 1'b1;
    @(posedge clk);
    special_trigger <= 1'b0;
    bus(0, `TMC_OFF_LOW, 32'h0);
    check_val("trigger low", 32'h0, rd);
    special_trigger <= 1'b1;
    bus(1, `TMC_OFF_LOW, 32'h5A);
    special_trigger <= 1'b0;
    bus(0, `TMC_OFF_LOW, 32'h0);
    check_val("write beats trigger", 32'h5A, rd);
    $display("test overflow done");
    bus(1, `TMC_OFF_CTRL, 32'h0);
    bus(1, `TMC_OFF_LOW, {24'h0, v[23:16]});
    bus(1, `TMC_OFF_HIGH, {24'h0, v[31:24]});
    bus(0, `TMC_OFF_HIGH, 32'h0);
    check_val("narrow high", {24'h0, v[31:24]}, rd);
    bus(0, `TMC_OFF_LOW, 32'h0);
    check_val("narrow low", {24'h0, v[23:16]}, rd);
    $display("test narrow done");
    bus(1, `TMC_OFF_CTRL, 32'h01);
    bus(1, `TMC_OFF_LOW, 32'h0);
    bus(0, `TMC_OFF_LOW, 32'h0);
    v = rd;
    clk_en <= 1'b0;
    repeat (40) @(posedge clk);
    clk_en <= 1'b1;
    bus(0, `TMC_OFF_LOW, 32'h0);
    // Only three enabled edges pass, so at most one tick
    check_near("frozen count", int'(v), rd);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    check_val("reset claim", 32'h0, osc_pins_claimed);
    bus(0, `TMC_OFF_CTRL, 32'h0);
    // Control bit 6 still follows the live system clock level
    check_val("reset control", 32'h40, rd);
    bus(0, `TMC_OFF_LOW, 32'h0);
    check_val("reset count", 32'h0, rd);
    $display("test freeze done");
    for (int m = 0; m < 3; m++) begin
      ctl = (m == 0) ? 8'h03 : (m == 1) ? 8'h07 : 8'h0F;
      pm_sleep <= (m != 0);
      bus(1, `TMC_OFF_CTRL, {24'h0, ctl});
      bus(1, `TMC_OFF_LOW, 32'h0);
      check_val("osc enable", 32'(m == 2), osc_enable);
      check_val("pins claimed", 32'h1, osc_pins_claimed);
      n = 1 + int'(rnd() % 40);
      u_src.burst(n, m == 2);
      repeat (8) @(posedge clk);
      bus(0, `TMC_OFF_LOW, 32'h0);
      check_val("edge count", 32'(n), rd);
      pm_sleep <= 1'b0;
    end
    $display("test external done");
    finish_test();
  end
endmodule
